// >>> shared/dsct_pkg.sv
// constants, offsets and types of the dual conversion timing control block
package dsct_pkg;
    localparam int CLK_NS = 40;
    // times as printed, in ns
    localparam int T_BUSY_MAX_N_NS  = 1750;
    localparam int T_BUSY_MAX_LP_NS = 2000;
    localparam int T_CNV_BUSY_NS    = 32;
    localparam int T_EOC_BUSY_NS    = 10;
    localparam int T_CNV_EOC_NS     = 30;
    localparam int T_EOC_A_N_NS     = 1000;
    localparam int T_EOC_A_LP_NS    = 1250;
    localparam int T_EOC_GAP_NS     = 45;
    localparam int T_EOC_B_NS       = 750;
    localparam int T_DATA_BUSY_NS   = 14;
    localparam int T_SYNC_RDC_N_NS  = 250;
    localparam int T_SYNC_RDC_LP_NS = 500;
    localparam int T_SYNC_RAC_N_NS  = 750;
    localparam int T_SYNC_RAC_LP_NS = 1000;
    localparam int T_SYNC_BUSY_NS   = 25;
    localparam int SCLK_PER_NS [4]  = '{40, 70, 140, 280};
    localparam int BUSY_RAC_N_NS [4]  = '{3250, 4250, 6250, 10750};
    localparam int BUSY_RAC_LP_NS [4] = '{3500, 4500, 6500, 11000};
    // cycle counts: maxima round down, minima up, typicals to nearest
    localparam int BUSY_MAX_N_CYC  = T_BUSY_MAX_N_NS / CLK_NS;
    localparam int BUSY_MAX_LP_CYC = T_BUSY_MAX_LP_NS / CLK_NS;
    localparam int EOC_A_MAX_N_CYC  = T_EOC_A_N_NS / CLK_NS;
    localparam int EOC_A_MAX_LP_CYC = T_EOC_A_LP_NS / CLK_NS;
    localparam int EOC_B_MAX_CYC    = T_EOC_B_NS / CLK_NS;
    localparam int GAP_CYC = (T_EOC_GAP_NS + CLK_NS - 1) / CLK_NS;
    localparam int END_CYC = (T_EOC_BUSY_NS + CLK_NS - 1) / CLK_NS;
    localparam int SYNC_RDC_N_CYC  = (T_SYNC_RDC_N_NS + CLK_NS / 2) / CLK_NS;
    localparam int SYNC_RDC_LP_CYC = (T_SYNC_RDC_LP_NS + CLK_NS / 2) / CLK_NS;
    localparam int SYNC_RAC_N_CYC  = (T_SYNC_RAC_N_NS + CLK_NS / 2) / CLK_NS;
    localparam int SYNC_RAC_LP_CYC = (T_SYNC_RAC_LP_NS + CLK_NS / 2) / CLK_NS;
    // chosen phase lengths, kept below the maxima above
    localparam int CONV_A_N_CYC  = EOC_A_MAX_N_CYC - 5;
    localparam int CONV_A_LP_CYC = EOC_A_MAX_LP_CYC - 6;
    localparam int CONV_B_CYC    = EOC_B_MAX_CYC - 2;
    // register map (byte offsets) and control fields
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_RESULT = 8'h08;
    localparam int CTL_LOW_POWER = 0;
    localparam int CTL_SERIAL    = 1;
    localparam int CTL_MASTER    = 2;
    localparam int CTL_AFTER     = 3;
    localparam int CTL_DIV_LO    = 4;
    localparam int CTL_WORD_B    = 6;
    localparam logic [6:0] CTRL_RESET = 7'h00;
    typedef enum logic [5:0] {
        DSCT_IDLE   = 6'h01,
        DSCT_CONV_A = 6'h02,
        DSCT_GAP    = 6'h04,
        DSCT_CONV_B = 6'h08,
        DSCT_END    = 6'h10,
        DSCT_WAIT   = 6'h20
    } dsct_state_t;
endpackage

// >>> verilog/dsct_ctrl.sv
// dual channel conversion sequencer with parallel, serial and apb ports
//
// Implementation choices: the APB register port and the register addresses.
module dsct_ctrl #(
    parameter int DW = 16
) (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [7:0]    paddr,
    input  wire logic [31:0]   pwdata,
    output logic [31:0]        prdata,
    output logic               pready,
    output logic               pslverr,
    input  wire logic          conversion_start_n,
    input  wire logic          input_pair_select,
    input  wire logic [DW-1:0] sample_a,
    input  wire logic [DW-1:0] sample_b,
    output logic               busy,
    output logic               end_of_conversion,
    output logic [DW-1:0]      parallel_data,
    output logic               serial_data_out,
    output logic               serial_clock_out,
    output logic               frame_sync,
    input  wire logic          serial_clock_in,
    input  wire logic          serial_data_in
);
    typedef struct packed {
        dsct_pkg::dsct_state_t state;
        logic [9:0]            el;
        logic [5:0]            ph;
        logic                  start_q;
        logic [DW-1:0]         samp_a;
        logic [DW-1:0]         samp_b;
        logic [DW-1:0]         res_a;
        logic [DW-1:0]         res_b;
        logic [DW-1:0]         par;
        logic                  pair;
        logic [6:0]            ctrl;
        logic                  ser_act;
        logic                  ser_done;
        logic                  sclk;
        logic                  sdo;
        logic [DW-1:0]         sh;
        logic [3:0]            bits;
        logic [2:0]            half;
        logic                  sclk_in_q;
        logic [31:0]           rdata;
        logic                  err;
    } dsct_reg_t;

    dsct_reg_t st;
    dsct_reg_t next_st;

    // half period in pclk cycles, rounded, never below one
    function automatic logic [2:0] dsct_half(input logic [1:0] div);
        int h;
        h = (dsct_pkg::SCLK_PER_NS[div] + dsct_pkg::CLK_NS)
            / (2 * dsct_pkg::CLK_NS);
        if (h < 1)
            h = 1;
        return 3'(h);
    endfunction

    logic       start_fall;
    logic       lp;
    logic       master;
    logic       rac;
    logic [1:0] div;
    logic [2:0] half_cyc;
    logic [9:0] a_len;
    logic [9:0] sync_rdc;
    logic [9:0] sync_rac;

    assign lp       = st.ctrl[dsct_pkg::CTL_LOW_POWER];
    assign master   = st.ctrl[dsct_pkg::CTL_SERIAL]
                      & st.ctrl[dsct_pkg::CTL_MASTER];
    assign rac      = master & st.ctrl[dsct_pkg::CTL_AFTER];
    assign div      = st.ctrl[dsct_pkg::CTL_DIV_LO +: 2];
    // during-convert frames run at the fastest rate to fit in busy
    assign half_cyc = rac ? dsct_half(div) : dsct_half(2'h0);
    assign a_len    = lp ? 10'(dsct_pkg::CONV_A_LP_CYC)
                         : 10'(dsct_pkg::CONV_A_N_CYC);
    assign sync_rdc = lp ? 10'(dsct_pkg::SYNC_RDC_LP_CYC)
                         : 10'(dsct_pkg::SYNC_RDC_N_CYC);
    assign sync_rac = lp ? 10'(dsct_pkg::SYNC_RAC_LP_CYC)
                         : 10'(dsct_pkg::SYNC_RAC_N_CYC);

    // a start during busy is ignored; the host must not send one
    assign start_fall = st.start_q & ~conversion_start_n
                        & (st.state == dsct_pkg::DSCT_IDLE);

    // combinational so both rise in the start cycle itself
    assign busy = (st.state != dsct_pkg::DSCT_IDLE) | start_fall;
    assign end_of_conversion = (st.state == dsct_pkg::DSCT_CONV_A)
                               | (st.state == dsct_pkg::DSCT_CONV_B)
                               | start_fall;

    assign parallel_data    = st.par;
    assign serial_data_out  = st.sdo;
    assign serial_clock_out = st.sclk;
    assign frame_sync       = st.ser_act;
    assign prdata           = st.rdata;
    assign pslverr          = st.err;
    assign pready           = 1'b1;

    always_comb begin
        logic [DW-1:0] word;
        word = st.ctrl[dsct_pkg::CTL_WORD_B] ? st.res_b : st.res_a;
        next_st = st;
        next_st.start_q   = conversion_start_n;
        next_st.sclk_in_q = serial_clock_in;
        if (st.state != dsct_pkg::DSCT_IDLE)
            next_st.el = st.el + 10'h001;
        next_st.ph = st.ph + 6'h01;
        case (st.state)
            dsct_pkg::DSCT_IDLE: begin
                if (start_fall) begin
                    // both channels held at the same instant
                    next_st.samp_a   = sample_a;
                    next_st.samp_b   = sample_b;
                    next_st.pair     = input_pair_select;
                    next_st.el       = 10'h001;
                    next_st.ph       = 6'h00;
                    next_st.ser_done = 1'b0;
                    next_st.state    = dsct_pkg::DSCT_CONV_A;
                end
            end
            dsct_pkg::DSCT_CONV_A: begin
                if (10'(st.ph) == a_len - 10'h001) begin
                    next_st.ph    = 6'h00;
                    next_st.state = dsct_pkg::DSCT_GAP;
                end
            end
            dsct_pkg::DSCT_GAP: begin
                if (st.ph == 6'(dsct_pkg::GAP_CYC - 1)) begin
                    next_st.ph    = 6'h00;
                    next_st.state = dsct_pkg::DSCT_CONV_B;
                end
            end
            dsct_pkg::DSCT_CONV_B: begin
                if (st.ph == 6'(dsct_pkg::CONV_B_CYC - 1)) begin
                    next_st.ph    = 6'h00;
                    next_st.res_a = st.samp_a;
                    next_st.res_b = st.samp_b;
                    // data settles a full cycle before busy can fall
                    next_st.par   = st.ctrl[dsct_pkg::CTL_WORD_B]
                                    ? st.samp_b : st.samp_a;
                    if (st.ctrl[dsct_pkg::CTL_SERIAL] & ~master)
                        next_st.sh = st.ctrl[dsct_pkg::CTL_WORD_B]
                                     ? st.samp_b : st.samp_a;
                    if (master & (st.ser_act | ~st.ser_done))
                        next_st.state = dsct_pkg::DSCT_WAIT;
                    else
                        next_st.state = dsct_pkg::DSCT_END;
                end
            end
            dsct_pkg::DSCT_END: begin
                if (st.ph == 6'(dsct_pkg::END_CYC - 1))
                    next_st.state = dsct_pkg::DSCT_IDLE;
            end
            dsct_pkg::DSCT_WAIT: begin
                // busy drops one cycle after the frame marker falls
                if (~st.ser_act & st.ser_done)
                    next_st.state = dsct_pkg::DSCT_IDLE;
            end
            default: next_st.state = dsct_pkg::DSCT_IDLE;
        endcase

        // master frame start: previous word during, new word after
        if (master & ~st.ser_act & ~st.ser_done) begin
            if ((~rac & (st.state != dsct_pkg::DSCT_IDLE)
                      & (st.el == sync_rdc - 10'h001))
                | (rac & (st.state == dsct_pkg::DSCT_WAIT)
                      & (st.el >= sync_rac - 10'h001))) begin
                next_st.ser_act = 1'b1;
                next_st.sh      = word;
                next_st.sdo     = word[DW-1];
                next_st.sclk    = 1'b0;
                next_st.bits    = 4'h0;
                next_st.half    = 3'h0;
            end
        end
        // data changes on the falling edge, host samples on the rise
        if (st.ser_act) begin
            if (st.half == half_cyc - 3'h1) begin
                next_st.half = 3'h0;
                next_st.sclk = ~st.sclk;
                if (st.sclk) begin
                    if (st.bits == 4'(DW - 1)) begin
                        next_st.ser_act  = 1'b0;
                        next_st.ser_done = 1'b1;
                    end else begin
                        next_st.bits = st.bits + 4'h1;
                        next_st.sh   = {st.sh[DW-2:0], 1'b0};
                        next_st.sdo  = st.sh[DW-2];
                    end
                end
            end else begin
                next_st.half = st.half + 3'h1;
            end
        end
        // slave mode: shift on the external clock, chain in serial_data_in
        if (st.ctrl[dsct_pkg::CTL_SERIAL] & ~master
            & serial_clock_in & ~st.sclk_in_q) begin
            next_st.sdo = st.sh[DW-1];
            next_st.sh  = {st.sh[DW-2:0], serial_data_in};
        end

        // apb: read data and error prepared in the setup cycle
        if (psel & ~penable) begin
            next_st.err   = 1'b0;
            next_st.rdata = 32'h0000_0000;
            case (paddr)
                dsct_pkg::OFS_CTRL:   next_st.rdata = {25'h0, st.ctrl};
                dsct_pkg::OFS_STATUS: next_st.rdata = {24'h0, st.state,
                                          st.pair, busy};
                dsct_pkg::OFS_RESULT: next_st.rdata = {st.res_b, st.res_a};
                default:              next_st.err   = 1'b1;
            endcase
        end
        if (psel & penable & pwrite & (paddr == dsct_pkg::OFS_CTRL))
            next_st.ctrl = pwdata[6:0];
        if (psel & penable & st.err)
            next_st.err = 1'b1;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st       <= '0;
            st.state <= dsct_pkg::DSCT_IDLE;
            st.start_q <= 1'b1;
            st.sclk_in_q <= 1'b0;
            st.ctrl  <= dsct_pkg::CTRL_RESET;
        end else begin
            st <= next_st;
        end
    end

    logic [9:0] busy_lim;
    logic [9:0] rac_lim;
    assign busy_lim = lp ? 10'(dsct_pkg::BUSY_MAX_LP_CYC)
                         : 10'(dsct_pkg::BUSY_MAX_N_CYC);
    assign rac_lim  = lp ? 10'(dsct_pkg::BUSY_RAC_LP_NS[div] / dsct_pkg::CLK_NS)
                         : 10'(dsct_pkg::BUSY_RAC_N_NS[div] / dsct_pkg::CLK_NS);

    a_busy_rise: assert property (@(posedge pclk) disable iff (!presetn)
        start_fall |-> busy ##1 (st.state == dsct_pkg::DSCT_CONV_A))
        else $error("busy did not rise with start");
    a_eoc_rise: assert property (@(posedge pclk) disable iff (!presetn)
        start_fall |-> end_of_conversion ##1 end_of_conversion)
        else $error("conversion flag did not rise with start");
    a_busy_max: assert property (@(posedge pclk) disable iff (!presetn)
        (st.state != dsct_pkg::DSCT_IDLE && !rac) |-> st.el < busy_lim)
        else $error("busy held too long");
    // el is stale in the start cycle, so only counted states are checked
    a_data_valid: assert property (@(posedge pclk) disable iff (!presetn)
        (st.state == dsct_pkg::DSCT_CONV_B)
        && (st.ph == 6'(dsct_pkg::CONV_B_CYC - 1)) |-> st.el < busy_lim)
        else $error("parallel data loaded too late");
    a_capture_pair: assert property (@(posedge pclk) disable iff (!presetn)
        start_fall |=> (st.samp_a == $past(sample_a))
                       && (st.samp_b == $past(sample_b)))
        else $error("channel samples not taken together");
    a_eoc_a_width: assert property (@(posedge pclk) disable iff (!presetn)
        (st.state == dsct_pkg::DSCT_CONV_A) |-> st.el <= 10'(lp
            ? dsct_pkg::EOC_A_MAX_LP_CYC : dsct_pkg::EOC_A_MAX_N_CYC))
        else $error("channel A flag too long");
    a_eoc_gap: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(end_of_conversion) && st.state == dsct_pkg::DSCT_GAP
        |-> !end_of_conversion[*2])
        else $error("flag gap too short");
    a_eoc_b_width: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(end_of_conversion) && st.state == dsct_pkg::DSCT_CONV_B
        |-> ##18 !end_of_conversion)
        else $error("channel B flag too long");
    a_data_before: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(busy) |-> $stable(parallel_data) && $past(st.state) != dsct_pkg::DSCT_CONV_B)
        else $error("data changed as busy fell");
    a_sync_rdc: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(frame_sync) && !rac |-> st.el == sync_rdc)
        else $error("during-read marker mistimed");
    a_sync_rac: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(frame_sync) && rac
        |-> st.el >= sync_rac && st.state == dsct_pkg::DSCT_WAIT)
        else $error("after-read marker mistimed");
    a_sclk_idle: assert property (@(posedge pclk) disable iff (!presetn)
        !frame_sync |-> !serial_clock_out)
        else $error("serial clock runs outside a frame");
    a_sdo_on_fall: assert property (@(posedge pclk) disable iff (!presetn)
        frame_sync && $past(frame_sync) && $changed(serial_data_out)
        |-> $fell(serial_clock_out))
        else $error("serial data changed off the falling clock");
    a_word_len: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(frame_sync) |-> $past(st.bits) == 4'(DW - 1))
        else $error("serial frame not one full word");
    a_sync_busy: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(frame_sync) && st.state == dsct_pkg::DSCT_WAIT
        |=> st.state == dsct_pkg::DSCT_IDLE)
        else $error("busy late after marker");
    a_busy_rac: assert property (@(posedge pclk) disable iff (!presetn)
        (st.state != dsct_pkg::DSCT_IDLE && rac) |-> st.el < rac_lim)
        else $error("after-read busy too long");
endmodule

// >>> test/dsct_host_model.sv
// host model: starts conversions and clocks the slave serial port
module dsct_host_model (
    input  wire logic   pclk,
    input  wire logic   busy,
    input  wire logic   serial_data_out,
    output logic        conversion_start_n,
    output logic        input_pair_select,
    output logic        serial_clock_in,
    output logic        serial_data_in,
    output logic [15:0] slave_word
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        conversion_start_n = 1'b1;
        input_pair_select = 1'b0;
        serial_clock_in = 1'b0;
        serial_data_in = 1'b0;
        slave_word = 16'h0000;
    end
    // strobe held low one cycle, then released
    always @(posedge pclk) begin
        if (!conversion_start_n)
            conversion_start_n <= 1'b1;
    end
    // daisy chain input never sits still, so a stale bit cannot pass
    always @(posedge pclk) serial_data_in <= ~serial_data_in;
    task automatic start(input logic p);
        @(posedge pclk);
        while (busy !== 1'b0) @(posedge pclk);
        input_pair_select <= p;
        repeat (7) @(posedge pclk);
        conversion_start_n <= 1'b0;
    endtask
    // slow external clock: the port samples it synchronously
    task automatic slave_read();
        repeat (16) begin
            @(posedge pclk);
            serial_clock_in <= 1'b1;
            repeat (4) @(posedge pclk);
            serial_clock_in <= 1'b0;
            repeat (4) @(posedge pclk);
            slave_word = {slave_word[14:0], serial_data_out};
        end
    endtask
endmodule

// >>> test/test_dsct_ctrl.sv
// testbench of the dual conversion timing control block
module test_dsct_ctrl;
    timeunit 1ns;
    timeprecision 1ns;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q;
    logic [15:0] sample_a, sample_b, pdat, sword, mword, last;
    logic        busy, eoc, sdo, sclk, fsync, cnv_n, pair, sclk_in, sdi;
    logic        perr;
    int          n_fail, cmp_count, lp, c, bmax;
    int          n_bsy, n_a, n_g, n_b, t_bf, t_sr, t_sf, n_bit, per, t_lr;
    int          hp [4] = '{1, 1, 2, 4};
    dsct_ctrl u_dsct_ctrl (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .conversion_start_n(cnv_n),
        .input_pair_select(pair), .sample_a(sample_a), .sample_b(sample_b),
        .busy(busy), .end_of_conversion(eoc), .parallel_data(pdat),
        .serial_data_out(sdo), .serial_clock_out(sclk), .frame_sync(fsync),
        .serial_clock_in(sclk_in), .serial_data_in(sdi));
    dsct_host_model u_dsct_host_model (
        .pclk(pclk), .busy(busy), .serial_data_out(sdo),
        .conversion_start_n(cnv_n), .input_pair_select(pair),
        .serial_clock_in(sclk_in), .serial_data_in(sdi),
        .slave_word(sword));
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    task automatic complete_run();
        if (n_fail == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    task automatic rng(input string nm, input int lo, input int hi,
                       input int g);
        cmp_count++;
        if (g < lo || g > hi) begin
            n_fail++;
            $display("MISMATCH %s expected %0d..%0d seen %0d", nm, lo, hi, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (pready !== 1'b1) begin
            n_fail++;
            $display("MISMATCH apb pready expected 1 seen %b", pready);
        end
        q = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // one conversion; samples move after the start to prove the capture
    task automatic conv(input logic p, input logic [15:0] a, b, w,
                        input int alim);
        logic e0, b0, sp, fp;
        logic [15:0] pv;
        int ph;
        {n_bsy, n_a, n_g, n_b, n_bit, per, t_lr, ph} = '0;
        {t_bf, t_sr, t_sf} = {-32'sd1, -32'sd1, -32'sd1};
        {sp, fp, mword, pv} = '0;
        sample_a <= a;
        sample_b <= b;
        u_dsct_host_model.start(p);
        for (int n = 0; n < 900; n++) begin
            @(negedge pclk);
            if (n == 0)
                {b0, e0} = {busy, eoc};
            if (busy === 1'b1)
                n_bsy++;
            else if (t_bf < 0) begin
                t_bf = n;
                chk("data before busy low", w, pv);
            end
            pv = pdat;
            if (ph == 0 && !eoc) ph = 1;
            if (ph == 1 && eoc) ph = 2;
            if (ph == 2 && !eoc) ph = 3;
            n_a += (ph == 0);
            n_g += (ph == 1);
            n_b += (ph == 2);
            if (fsync && !fp) t_sr = n;
            if (!fsync && fp) t_sf = n;
            if (fsync && sclk && !sp) begin
                mword = {mword[14:0], sdo};
                n_bit++;
                if (n_bit == 2) per = n - t_lr;
                t_lr = n;
            end
            {fp, sp} = {fsync, sclk};
            if (t_bf >= 0 && !fsync) break;
            if (n == 2) begin
                @(posedge pclk);
                sample_a <= ~a;
                sample_b <= ~b;
            end
        end
        chk("busy at start", 1'b1, b0);
        chk("eoc at start", 1'b1, e0);
        rng("eoc A high", 1, alim, n_a);
        rng("eoc gap", dsct_pkg::GAP_CYC, 99, n_g);
        rng("eoc B high", 1, dsct_pkg::EOC_B_MAX_CYC, n_b);
        rng("busy after eoc", n_a + n_g + n_b + dsct_pkg::END_CYC, 999, t_bf);
        apb(1'b0, dsct_pkg::OFS_RESULT, 32'h0);
        chk("result pair", {b, a}, q);
        apb(1'b0, dsct_pkg::OFS_STATUS, 32'h0);
        chk("pair latched", p, q[1]);
    endtask
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {sample_a, sample_b, n_fail, cmp_count} = '0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, dsct_pkg::OFS_CTRL, 32'h0);
        chk("ctrl reset", {25'h0, dsct_pkg::CTRL_RESET}, q);
        apb(1'b0, dsct_pkg::OFS_STATUS, 32'h0);
        chk("status reset", {24'h0, dsct_pkg::DSCT_IDLE, 2'b00}, q);
        apb(1'b0, 8'h0C, 32'h0);
        chk("unmapped error", 1'b1, perr);
        chk("unmapped data", 32'h0, q);
        apb(1'b1, dsct_pkg::OFS_RESULT, 32'hFFFF_FFFF);
        apb(1'b0, dsct_pkg::OFS_RESULT, 32'h0);
        chk("result read only", 32'h0, q);
        apb(1'b1, dsct_pkg::OFS_CTRL, 32'h0);
        conv(1'b1, 16'h1234, 16'hABCD, 16'h1234, dsct_pkg::EOC_A_MAX_N_CYC);
        rng("busy normal", 1, dsct_pkg::BUSY_MAX_N_CYC, n_bsy);
        last = 16'h1234;
        for (lp = 0; lp < 2; lp++) begin
            apb(1'b1, dsct_pkg::OFS_CTRL, 32'h6 | lp);
            conv(1'b0, 16'h2345 + lp, 16'h5432, 16'h2345 + lp,
                 lp ? dsct_pkg::EOC_A_MAX_LP_CYC : dsct_pkg::EOC_A_MAX_N_CYC);
            c = lp ? dsct_pkg::SYNC_RDC_LP_CYC : dsct_pkg::SYNC_RDC_N_CYC;
            rng("frame rise during", c - 1, c + 1, t_sr);
            chk("word during", {16'h0, last}, {16'h0, mword});
            rng("bits during", 16, 16, n_bit);
            last = 16'h2345 + lp;
        end
        apb(1'b1, dsct_pkg::OFS_CTRL, 32'h41);
        conv(1'b0, 16'h8001, 16'h7FFE, 16'h7FFE, dsct_pkg::EOC_A_MAX_LP_CYC);
        rng("busy low power", 1, dsct_pkg::BUSY_MAX_LP_CYC, n_bsy);
        for (lp = 0; lp < 2; lp++) begin
            for (c = 0; c < 4; c++) begin
                apb(1'b1, dsct_pkg::OFS_CTRL, 32'hE | lp | (c << 4));
                conv(1'b1, 16'hC000 + c, 16'h3FFF, 16'hC000 + c,
                     lp ? dsct_pkg::EOC_A_MAX_LP_CYC : dsct_pkg::EOC_A_MAX_N_CYC);
                bmax = (lp ? dsct_pkg::BUSY_RAC_LP_NS[c]
                           : dsct_pkg::BUSY_RAC_N_NS[c]) / dsct_pkg::CLK_NS;
                rng("busy after read", 1, bmax, n_bsy);
                rng("frame rise after", dsct_pkg::SYNC_RAC_N_CYC, bmax, t_sr);
                rng("clock period", 2 * hp[c], 2 * hp[c], per);
                rng("busy after frame", 1, 1, t_bf - t_sf);
                chk("word after", 32'hC000 + c, {16'h0, mword});
            end
        end
        apb(1'b1, dsct_pkg::OFS_CTRL, 32'h2);
        conv(1'b1, 16'h5A96, 16'h0F0F, 16'h5A96, dsct_pkg::EOC_A_MAX_N_CYC);
        u_dsct_host_model.slave_read();
        chk("slave word", 32'h5A96, {16'h0, sword});
        complete_run();
    end
    // generous span: every test above ends within a few thousand cycles
    initial begin
        repeat (20000) @(posedge pclk);
        n_fail++;
        complete_run();
    end
endmodule
